// *** adcs_regs.svh ***
// Purpose: register map, field positions, reset values and timing counts of the sequencer
// Assumes: 32-bit Avalon-MM slave with byte addresses, 8-bit registers in lane 0
// Notes: counts are in conv_bit_period ticks or core_clk cycles as named
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

`define ADCS_ADDR_W 5
`define ADCS_OFF_CONTROL_CHANNEL 5'h00
`define ADCS_OFF_REFERENCE_PINS 5'h04
`define ADCS_OFF_TIMING_FORMAT 5'h08
`define ADCS_OFF_RESULT_HIGH 5'h0C
`define ADCS_OFF_RESULT_LOW 5'h10
`define ADCS_OFF_STATUS 5'h14
`define ADCS_OFF_PORT_DATA 5'h18

// converter_control_channel fields
`define ADCS_CC_ON_BIT 0
`define ADCS_CC_RUN_BIT 1
`define ADCS_CC_CHAN_LSB 2
// converter_reference_pins fields
`define ADCS_RP_CFG_LSB 0
`define ADCS_RP_VREF_LSB 4
// converter_timing_format fields
`define ADCS_TF_CLK_LSB 0
`define ADCS_TF_ACQ_LSB 3
`define ADCS_TF_JUSTIFY_BIT 7
// status fields
`define ADCS_ST_DONE_BIT 0
`define ADCS_ST_BUSY_BIT 1

// reset values and the analog pin limit
`define ADCS_RST_PORT_CFG_ANALOG 4'h0
`define ADCS_RST_PORT_CFG_DIGITAL 4'h7
`define ADCS_RST_RESULT 8'h00
`define ADCS_ANALOG_LIMIT 5'h0F

// timing counts and the compare trigger mode
`define ADCS_CONV_HOLD_TAD 5'd1
`define ADCS_WAIT_TAD 5'd2
`define ADCS_INSTR_CYCLE_CLKS 3'd4
`define ADCS_DIV_2 7'd2
`define ADCS_DIV_4 7'd4
`define ADCS_DIV_8 7'd8
`define ADCS_DIV_16 7'd16
`define ADCS_DIV_32 7'd32
`define ADCS_DIV_64 7'd64
`define ADCS_ACQ_TAD_1 5'd2
`define ADCS_ACQ_TAD_2 5'd4
`define ADCS_ACQ_TAD_3 5'd6
`define ADCS_ACQ_TAD_4 5'd8
`define ADCS_ACQ_TAD_5 5'd12
`define ADCS_ACQ_TAD_6 5'd16
`define ADCS_ACQ_TAD_7 5'd20
`define ADCS_COMPARE_TRIGGER_MODE 4'hB

`endif

// *** adcs_pkg.sv ***
// Purpose: types shared by the conversion sequencer files
// Assumes: adcs_regs.svh supplies all numeric constants
// Notes: carriers are packed structs
package adcs_pkg;

	typedef enum logic [2:0] {
		ADCS_OFF,
		ADCS_SAMPLE,
		ADCS_DELAY,
		ADCS_ACQ,
		ADCS_HOLD,
		ADCS_CONV,
		ADCS_WAIT
	} adcs_state_t;

	typedef struct packed {
		logic [4:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} adcs_avs_req_t;

	typedef struct packed {
		logic sample_enable;
		logic discharge;
		logic [9:0] dac_code;
		logic [3:0] channel;
		logic [1:0] vref_select;
	} adcs_analog_out_t;

	typedef struct packed {
		logic [5:0] count;
		logic tick;
	} adcs_tad_state_t;

endpackage

// *** adcs_tad_gen.sv ***
// Purpose: conv_bit_period tick generator from core_clk or the rc_conversion_clock
// Assumes: rc_edge is already synchronised to core_clk, one cycle wide
// Notes: the counter restarts whenever enable drops, so the first tick is a full period
`timescale 1ns/1ps
`include "adcs_regs.svh"
module adcs_tad_gen
	import adcs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [2:0] conv_clock_select,
	input wire logic rc_edge,
	output logic tad_tick
);
	adcs_tad_state_t r;
	adcs_tad_state_t next_r;
	logic [6:0] divide;

	// oscillator periods per conv_bit_period, x11 picks the rc clock
	always_comb begin
		case (conv_clock_select)
			3'b000: divide = `ADCS_DIV_2;
			3'b100: divide = `ADCS_DIV_4;
			3'b001: divide = `ADCS_DIV_8;
			3'b101: divide = `ADCS_DIV_16;
			3'b010: divide = `ADCS_DIV_32;
			3'b110: divide = `ADCS_DIV_64;
			default: divide = `ADCS_DIV_2;
		endcase
	end

	// divider or rc edge pass-through
	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (!enable) begin
			next_r.count = 6'h00;
		end else if (conv_clock_select[1:0] == 2'b11) begin
			next_r.tick = rc_edge;
		end else if ({1'b0, r.count} == divide - 7'd1) begin
			next_r.count = 6'h00;
			next_r.tick = 1'b1;
		end else begin
			next_r.count = r.count + 6'd1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tad_tick = r.tick;
endmodule

// *** adcs_sequencer.sv ***
// Purpose: digital sequencer of a 10-bit successive-approximation converter
// Assumes: core_clk is the oscillator; pins and rc clock are asynchronous
// Notes: registers sit on an Avalon-MM slave that answers one cycle after a request
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "adcs_regs.svh"
module adcs_sequencer
	import adcs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire adcs_avs_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rc_conversion_clock,
	input wire logic comparator_high,
	input wire logic [7:0] port_pins,
	input wire logic port_two_analog_reset_fuse,
	input wire logic special_event,
	input wire logic [3:0] compare_mode_field,
	output logic timer_reset,
	output adcs_analog_out_t analog_out
);
	typedef struct packed {
		adcs_state_t state;
		logic [4:0] tad_cnt;
		logic [2:0] dly_cnt;
		logic [3:0] bit_idx;
		logic converter_on;
		logic run;
		logic [3:0] channel_select;
		logic [1:0] vref_select;
		logic [3:0] port_analog_config;
		logic result_justify;
		logic [2:0] acq_time_select;
		logic [2:0] conv_clock_select;
		logic [7:0] result_high_byte;
		logic [7:0] result_low_byte;
		logic conversion_done_flag;
		logic waitrequest;
		logic [31:0] readdata;
		logic timer_reset;
		logic fuse_loaded;
		adcs_analog_out_t analog;
		logic rc_s1;
		logic rc_s2;
		logic rc_s3;
		logic cmp_q;
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
	} adcs_core_t;

	adcs_core_t r;
	adcs_core_t next_r;
	logic tad_tick;
	logic tad_enable;
	logic [7:0] analog_mask;
	logic [4:0] acq_tads;
	logic [31:0] rd_value;
	logic served_write;
	logic ctrl_write;
	logic busy;
	logic [9:0] final_code;

	// bit period ticks run only while a timed phase is active
	assign tad_enable = (r.state == ADCS_ACQ) || (r.state == ADCS_HOLD) ||
		(r.state == ADCS_CONV) || (r.state == ADCS_WAIT);

	adcs_tad_gen u_tad_gen (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.enable(tad_enable),
		.conv_clock_select(r.conv_clock_select),
		.rc_edge(r.rc_s2 & ~r.rc_s3),
		.tad_tick(tad_tick)
	);

	// per-pin analog mask from the port analog configuration code
	generate
		for (genvar i = 0; i < 8; i++) begin : g_mask
			assign analog_mask[i] = ({1'b0, 4'(i)} + {1'b0, r.port_analog_config}) <
				`ADCS_ANALOG_LIMIT;
		end
	endgenerate

	// acquisition length in bit periods, code 000 is manual
	always_comb begin
		case (r.acq_time_select)
			3'd1: acq_tads = `ADCS_ACQ_TAD_1;
			3'd2: acq_tads = `ADCS_ACQ_TAD_2;
			3'd3: acq_tads = `ADCS_ACQ_TAD_3;
			3'd4: acq_tads = `ADCS_ACQ_TAD_4;
			3'd5: acq_tads = `ADCS_ACQ_TAD_5;
			3'd6: acq_tads = `ADCS_ACQ_TAD_6;
			3'd7: acq_tads = `ADCS_ACQ_TAD_7;
			default: acq_tads = 5'd0;
		endcase
	end

	// busy covers everything from a taken start to the end of conversion
	assign busy = (r.state == ADCS_DELAY) || (r.state == ADCS_ACQ) ||
		(r.state == ADCS_HOLD) || (r.state == ADCS_CONV);

	// read mux, unmapped offsets read zero
	always_comb begin
		rd_value = 32'h0000_0000;
		case (avs_req.address)
			`ADCS_OFF_CONTROL_CHANNEL: begin
				rd_value[`ADCS_CC_ON_BIT] = r.converter_on;
				rd_value[`ADCS_CC_RUN_BIT] = r.run;
				rd_value[`ADCS_CC_CHAN_LSB +: 4] = r.channel_select;
			end
			`ADCS_OFF_REFERENCE_PINS: begin
				rd_value[`ADCS_RP_CFG_LSB +: 4] = r.port_analog_config;
				rd_value[`ADCS_RP_VREF_LSB +: 2] = r.vref_select;
			end
			`ADCS_OFF_TIMING_FORMAT: begin
				rd_value[`ADCS_TF_CLK_LSB +: 3] = r.conv_clock_select;
				rd_value[`ADCS_TF_ACQ_LSB +: 3] = r.acq_time_select;
				rd_value[`ADCS_TF_JUSTIFY_BIT] = r.result_justify;
			end
			`ADCS_OFF_RESULT_HIGH: rd_value[7:0] = r.result_high_byte;
			`ADCS_OFF_RESULT_LOW: rd_value[7:0] = r.result_low_byte;
			`ADCS_OFF_STATUS: begin
				rd_value[`ADCS_ST_DONE_BIT] = r.conversion_done_flag;
				rd_value[`ADCS_ST_BUSY_BIT] = busy;
			end
			`ADCS_OFF_PORT_DATA: rd_value[7:0] = r.pin_s2 & ~analog_mask;
			default: rd_value = 32'h0000_0000;
		endcase
	end

	// a write takes effect only at the edge where waitrequest is seen low
	assign served_write = avs_req.write && !avs_req.read && !r.waitrequest &&
		avs_req.byteenable[0];
	assign ctrl_write = served_write && (avs_req.address == `ADCS_OFF_CONTROL_CHANNEL);

	// last trial bit decided by the comparator, used on the final bit period
	always_comb begin
		final_code = r.analog.dac_code;
		final_code[0] = r.cmp_q;
	end

	// main next-state process
	always_comb begin
		next_r = r;
		// synchronisers, first stage read only by the second
		next_r.rc_s1 = rc_conversion_clock;
		next_r.rc_s2 = r.rc_s1;
		next_r.rc_s3 = r.rc_s2;
		// comparator answers to our own dac_code flops; a single capture stage lets a
		// two-clock bit period decide on the current trial code, not the previous one
		next_r.cmp_q = comparator_high;
		next_r.pin_s1 = port_pins;
		next_r.pin_s2 = r.pin_s1;

		// fuse caught once, the first cycle after reset release
		if (!r.fuse_loaded) begin
			next_r.fuse_loaded = 1'b1;
			next_r.port_analog_config = port_two_analog_reset_fuse ?
				`ADCS_RST_PORT_CFG_ANALOG : `ADCS_RST_PORT_CFG_DIGITAL;
		end

		// bus handshake: one wait cycle, then a one-cycle acknowledge
		next_r.waitrequest = !((avs_req.read || avs_req.write) && r.waitrequest);
		if (avs_req.read && r.waitrequest) begin
			next_r.readdata = rd_value;
		end

		// register writes
		if (served_write) begin
			case (avs_req.address)
				`ADCS_OFF_CONTROL_CHANNEL: begin
					next_r.converter_on = avs_req.writedata[`ADCS_CC_ON_BIT];
					next_r.channel_select = avs_req.writedata[`ADCS_CC_CHAN_LSB +: 4];
					// run is only taken when the converter was already on
					if (!avs_req.writedata[`ADCS_CC_ON_BIT]) begin
						next_r.run = 1'b0;
					end else if (r.converter_on) begin
						next_r.run = avs_req.writedata[`ADCS_CC_RUN_BIT];
					end
				end
				`ADCS_OFF_REFERENCE_PINS: begin
					next_r.port_analog_config = avs_req.writedata[`ADCS_RP_CFG_LSB +: 4];
					next_r.vref_select = avs_req.writedata[`ADCS_RP_VREF_LSB +: 2];
				end
				`ADCS_OFF_TIMING_FORMAT: begin
					next_r.conv_clock_select = avs_req.writedata[`ADCS_TF_CLK_LSB +: 3];
					next_r.acq_time_select = avs_req.writedata[`ADCS_TF_ACQ_LSB +: 3];
					next_r.result_justify = avs_req.writedata[`ADCS_TF_JUSTIFY_BIT];
				end
				`ADCS_OFF_RESULT_HIGH: next_r.result_high_byte = avs_req.writedata[7:0];
				`ADCS_OFF_RESULT_LOW: next_r.result_low_byte = avs_req.writedata[7:0];
				`ADCS_OFF_STATUS: begin
					if (avs_req.writedata[`ADCS_ST_DONE_BIT]) begin
						next_r.conversion_done_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// compare trigger: timer always reset, run only while on
		next_r.timer_reset = special_event &&
			(compare_mode_field == `ADCS_COMPARE_TRIGGER_MODE);
		if (special_event && (compare_mode_field == `ADCS_COMPARE_TRIGGER_MODE) &&
			r.converter_on) begin
			next_r.run = 1'b1;
		end

		// sequencer; idle mode is invisible here, only the bit clock matters
		case (r.state)
			ADCS_OFF: begin
				if (r.converter_on) begin
					next_r.state = ADCS_WAIT;
					next_r.tad_cnt = 5'd0;
				end
			end
			ADCS_SAMPLE: begin
				// start needs only run; channel and pin direction never gate it
				if (r.run) begin
					if (r.acq_time_select == 3'd0) begin
						next_r.state = ADCS_DELAY;
						next_r.dly_cnt = 3'd0;
					end else begin
						next_r.state = ADCS_ACQ;
						next_r.tad_cnt = 5'd0;
					end
				end
			end
			ADCS_DELAY: begin
				// one instruction cycle before sampling stops
				if (r.dly_cnt == `ADCS_INSTR_CYCLE_CLKS - 3'd1) begin
					next_r.state = ADCS_HOLD;
					next_r.tad_cnt = 5'd0;
				end else begin
					next_r.dly_cnt = r.dly_cnt + 3'd1;
				end
			end
			ADCS_ACQ: begin
				if (tad_tick) begin
					if (r.tad_cnt == acq_tads - 5'd1) begin
						next_r.state = ADCS_HOLD;
						next_r.tad_cnt = 5'd0;
					end else begin
						next_r.tad_cnt = r.tad_cnt + 5'd1;
					end
				end
			end
			ADCS_HOLD: begin
				// first of the eleven bit periods, sample held
				if (tad_tick) begin
					next_r.state = ADCS_CONV;
					next_r.bit_idx = 4'd9;
					next_r.analog.dac_code = 10'h200;
				end
			end
			ADCS_CONV: begin
				if (tad_tick) begin
					if (r.bit_idx == 4'd0) begin
						// completion: result, run, done flag
						next_r.state = ADCS_WAIT;
						next_r.tad_cnt = 5'd0;
						next_r.run = 1'b0;
						next_r.conversion_done_flag = 1'b1;
						if (r.result_justify) begin
							next_r.result_high_byte = {6'h00, final_code[9:8]};
							next_r.result_low_byte = final_code[7:0];
						end else begin
							next_r.result_high_byte = final_code[9:2];
							next_r.result_low_byte = {final_code[1:0], 6'h00};
						end
					end else begin
						// keep or drop the trial bit, then try the next lower one
						next_r.analog.dac_code[r.bit_idx] = r.cmp_q;
						next_r.analog.dac_code[r.bit_idx - 4'd1] = 1'b1;
						next_r.bit_idx = r.bit_idx - 4'd1;
					end
				end
			end
			ADCS_WAIT: begin
				if (tad_tick) begin
					if (r.tad_cnt == `ADCS_WAIT_TAD - 5'd1) begin
						next_r.state = r.converter_on ? ADCS_SAMPLE : ADCS_OFF;
						next_r.tad_cnt = 5'd0;
					end else begin
						next_r.tad_cnt = r.tad_cnt + 5'd1;
					end
				end
			end
			default: next_r.state = ADCS_OFF;
		endcase

		// abort: run cleared or converter switched off while busy
		if (busy && ctrl_write && (!avs_req.writedata[`ADCS_CC_RUN_BIT] ||
			!avs_req.writedata[`ADCS_CC_ON_BIT])) begin
			next_r.state = ADCS_WAIT;
			next_r.tad_cnt = 5'd0;
			next_r.result_high_byte = r.result_high_byte;
			next_r.result_low_byte = r.result_low_byte;
			next_r.conversion_done_flag = r.conversion_done_flag;
		end
		if (!next_r.converter_on && (r.state == ADCS_SAMPLE)) begin
			next_r.state = ADCS_OFF;
		end

		// a done event beats a clear in the same cycle
		if ((r.state == ADCS_CONV) && tad_tick && (r.bit_idx == 4'd0) &&
			!(busy && ctrl_write && (!avs_req.writedata[`ADCS_CC_RUN_BIT] ||
			!avs_req.writedata[`ADCS_CC_ON_BIT]))) begin
			next_r.conversion_done_flag = 1'b1;
		end

		// analog controls follow the next state so they come from flops
		next_r.analog.sample_enable = (next_r.state == ADCS_SAMPLE) ||
			(next_r.state == ADCS_ACQ) || (next_r.state == ADCS_DELAY);
		next_r.analog.discharge = (next_r.state == ADCS_WAIT) &&
			(next_r.tad_cnt == `ADCS_WAIT_TAD - 5'd1);
		next_r.analog.channel = next_r.channel_select;
		next_r.analog.vref_select = next_r.vref_select;
	end

	// single state register; reset aborts and switches off
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.state <= ADCS_OFF;
			r.waitrequest <= 1'b1;
			r.port_analog_config <= `ADCS_RST_PORT_CFG_ANALOG;
			r.result_high_byte <= `ADCS_RST_RESULT;
			r.result_low_byte <= `ADCS_RST_RESULT;
		end else begin
			r <= next_r;
		end
	end

	assign avs_readdata = r.readdata;
	assign avs_waitrequest = r.waitrequest;
	assign timer_reset = r.timer_reset;
	assign analog_out = r.analog;
endmodule

// *** adcs_seq_asserts.sv ***
// Purpose: port-level checks of the conversion sequencer
// Assumes: watches only the ports of adcs_sequencer
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module adcs_seq_asserts
	import adcs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire adcs_avs_req_t avs_req,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic special_event,
	input wire logic [3:0] compare_mode_field,
	input wire logic timer_reset,
	input wire adcs_analog_out_t analog_out
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// lowest set bit of a trial code
	function automatic logic [9:0] low_bit(input logic [9:0] x);
		return x & (~x + 10'h001);
	endfunction

	// bus handshake and trigger steps
	sequence s_req_seen;
		(avs_req.read || avs_req.write) && avs_waitrequest;
	endsequence
	sequence s_ack_once;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	sequence s_trigger;
		special_event && compare_mode_field == 4'hB;
	endsequence

	a_bus_ack: assert property (s_req_seen |=> s_ack_once)
		else $error("request not acknowledged after one wait cycle");
	a_idle_no_ack: assert property (!(avs_req.read || avs_req.write) && avs_waitrequest
		|=> avs_waitrequest) else $error("acknowledge without a request");
	a_unmapped_zero: assert property (avs_req.read && avs_waitrequest && avs_req.address == 5'h1C
		|=> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
	a_readdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
		else $error("read data moved outside an acknowledge");
	a_timer_pulse: assert property (s_trigger |=> timer_reset ##1 !timer_reset)
		else $error("trigger gave no single timer reset pulse");
	a_timer_cause: assert property (timer_reset |->
		$past(special_event) && $past(compare_mode_field) == 4'hB)
		else $error("timer reset without a trigger");
	a_discharge_first: assert property ($rose(analog_out.sample_enable) |->
		$past(analog_out.discharge)) else $error("sample began without a discharge");
	a_discharge_apart: assert property (analog_out.discharge |-> !analog_out.sample_enable)
		else $error("discharge while sampling");
	a_dac_msb_first: assert property (
		$changed(analog_out.dac_code) && analog_out.dac_code != 10'h000
		&& analog_out.dac_code != 10'h200 && $past(analog_out.dac_code[0]) == 1'b0
		|-> low_bit(analog_out.dac_code) == (low_bit($past(analog_out.dac_code)) >> 1))
		else $error("trial bit not one below the previous");
endmodule

bind adcs_sequencer adcs_seq_asserts adcs_seq_asserts_inst (.core_clk(core_clk),
	.reset_n(reset_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .special_event(special_event),
	.compare_mode_field(compare_mode_field), .timer_reset(timer_reset),
	.analog_out(analog_out));

// *** adcs_analog_model.sv ***
// Purpose: input multiplexer, holding capacitor and comparator of the converter
// Assumes: one input level stands for the selected channel
// Notes: comparator output is unsynchronised, as on the real array
`timescale 1ns/1ps
module adcs_analog_model
	import adcs_pkg::*;
(
	input wire logic core_clk,
	input wire logic [9:0] input_level,
	input wire adcs_analog_out_t analog_out,
	output logic comparator_high
);
	logic [9:0] held = 10'h000;

	// holding charge: cleared by discharge, follows the input while sampling
	always @(posedge core_clk) begin
		if (analog_out.discharge) begin
			held <= 10'h000;
		end else if (analog_out.sample_enable) begin
			held <= input_level;
		end
	end

	// held charge against the trial code
	assign comparator_high = held > analog_out.dac_code;
endmodule

// *** adc_conversion_sequencer_test.sv ***
// Purpose: self-checking bench of the conversion sequencer
// Assumes: one wait cycle per register access, waits bounded by the bench
// Notes: results come from a bit-by-bit model of the converter
`timescale 1ns/1ps
`include "adcs_regs.svh"
module adc_conversion_sequencer_test
	import adcs_pkg::*;
;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic rc_conversion_clock = 1'b0;
	logic rc_run = 1'b0;
	logic fuse = 1'b0;
	logic special_event = 1'b0;
	logic [3:0] compare_mode_field = 4'h0;
	logic [7:0] port_pins = 8'h00;
	logic [9:0] input_level = 10'h000;
	adcs_avs_req_t req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic comparator_high;
	logic timer_reset;
	adcs_analog_out_t analog_out;
	logic [31:0] rd;
	logic se_q = 1'b0;
	logic dis_q = 1'b0;
	int miscompares = 0;
	int n_tests = 0;
	int seed = 32'h0000_8a45;
	int cyc = 0;
	int t_ack = 0;
	int t_fall = 0;
	int t_dis = 0;
	int acq_tad [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	logic [2:0] clk_code [6] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110};

	always #5 core_clk = ~core_clk;
	// rc clock runs only while a conversion uses it
	always #37 if (rc_run) rc_conversion_clock = ~rc_conversion_clock;

	// cycle count, end of sampling and start of discharge
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		se_q <= analog_out.sample_enable;
		dis_q <= analog_out.discharge;
		if (se_q && !analog_out.sample_enable) t_fall <= cyc;
		if (!dis_q && analog_out.discharge) t_dis <= cyc;
	end

	adcs_sequencer adcs_sequencer_inst (.core_clk(core_clk), .reset_n(reset_n), .avs_req(req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rc_conversion_clock(rc_conversion_clock), .comparator_high(comparator_high),
		.port_pins(port_pins), .port_two_analog_reset_fuse(fuse),
		.special_event(special_event), .compare_mode_field(compare_mode_field),
		.timer_reset(timer_reset), .analog_out(analog_out));
	adcs_analog_model adcs_analog_model_inst (.core_clk(core_clk), .input_level(input_level),
		.analog_out(analog_out), .comparator_high(comparator_high));

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string what);
		n_tests++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	// one Avalon access, held until waitrequest is seen low
	task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d);
		int n;
		n = 0;
		req.address <= a;
		req.read <= !wr;
		req.write <= wr;
		req.writedata <= {24'h00_0000, d};
		req.byteenable <= 4'hF;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20) check(1'b0, "bus timeout");
			if (n > 20) report_and_stop();
			@(posedge core_clk);
		end
		rd = avs_readdata;
		t_ack = cyc;
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic expect_reg(input logic [4:0] a, input logic [7:0] v, input string what);
		bus(a, 1'b0, 8'h00);
		check(rd === {24'h00_0000, v}, what);
	endtask

	task automatic pulse();
		@(posedge core_clk);
		special_event <= 1'b1;
		@(posedge core_clk);
		special_event <= 1'b0;
		@(posedge core_clk);
		check(timer_reset === (compare_mode_field == 4'hB), "timer reset");
	endtask

	// bit-by-bit model: a trial bit stays when the input is above it
	function automatic int sar(input int vin);
		int r;
		r = 0;
		for (int b = 9; b >= 0; b--) if (vin > (r | (1 << b))) r = r | (1 << b);
		return r;
	endfunction

	function automatic logic [7:0] pin_mask(input int cfg);
		for (int i = 0; i < 8; i++) pin_mask[i] = (i + cfg < 15);
	endfunction

	// one conversion: program, start, wait, compare with the model
	task automatic convert(input logic [2:0] ck, input logic [2:0] aq, input int div, input logic tr);
		int v, r, n, s;
		logic [3:0] ch;
		v = $random(seed) & 32'h0000_03FF;
		ch = 4'($random(seed));
		input_level <= v[9:0];
		r = sar(v);
		bus(`ADCS_OFF_TIMING_FORMAT, 1'b1, {aq[0], 1'b0, aq, ck});
		bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b1, {2'b00, ch, 2'b01});
		repeat (3 * div + 8) @(posedge core_clk);
		if (tr) pulse();
		else bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b1, {2'b00, ch, 2'b11});
		s = t_ack;
		bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b0, 8'h00);
		check(rd[1] === 1'b1 && analog_out.channel === ch, "run or channel");
		n = 0;
		while (rd[1] === 1'b1 && n < 2000) begin
			bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b0, 8'h00);
			n++;
		end
		check(rd[1] === 1'b0, "run never cleared");
		if (rd[1] !== 1'b0) report_and_stop();
		repeat (2 * div + 20) @(posedge core_clk);
		if (div > 0) begin
			n = (aq == 3'b000) ? 4 : acq_tad[aq] * div;
			check((t_fall - s - n) inside {[-3:3]}, "acquisition length");
			check((t_dis - t_fall - 12 * div) inside {[-4:4]}, "conversion length");
		end
		bus(`ADCS_OFF_RESULT_HIGH, 1'b0, 8'h00);
		check(rd[7:0] === (aq[0] ? 8'(r >> 8) : 8'(r >> 2)), "result high");
		bus(`ADCS_OFF_RESULT_LOW, 1'b0, 8'h00);
		check(rd[7:0] === (aq[0] ? 8'(r) : 8'(r << 6)), "result low");
		bus(`ADCS_OFF_STATUS, 1'b0, 8'h00);
		check(rd[0] === 1'b1, "done flag");
		bus(`ADCS_OFF_STATUS, 1'b1, 8'h01);
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		expect_reg(`ADCS_OFF_REFERENCE_PINS, 8'h07, "fuse digital reset");
		expect_reg(`ADCS_OFF_CONTROL_CHANNEL, 8'h00, "control reset");
		expect_reg(`ADCS_OFF_TIMING_FORMAT, 8'h00, "timing reset");
		expect_reg(5'h1C, 8'h00, "unmapped read");
		for (int c = 0; c < 16; c++) begin
			port_pins <= 8'($random(seed));
			bus(`ADCS_OFF_REFERENCE_PINS, 1'b1, 8'(c * 17));
			repeat (3) @(posedge core_clk);
			bus(`ADCS_OFF_PORT_DATA, 1'b0, 8'h00);
			check(rd === {24'h00_0000, port_pins & ~pin_mask(c)}, "port data");
			check(analog_out.vref_select === 2'(c), "reference select");
		end
		compare_mode_field <= 4'hB;
		pulse();
		expect_reg(`ADCS_OFF_CONTROL_CHANNEL, 8'h00, "trigger while off");
		bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b1, 8'h01);
		compare_mode_field <= 4'hA;
		pulse();
		expect_reg(`ADCS_OFF_CONTROL_CHANNEL, 8'h01, "trigger in another mode");
		compare_mode_field <= 4'hB;
		for (int a = 0; a < 8; a++) convert(3'b001, 3'(a), 8, 1'b0);
		for (int k = 0; k < 6; k++) convert(clk_code[k], 3'b001, 2 << k, 1'b0);
		rc_run <= 1'b1;
		convert(3'b011, 3'b010, 0, 1'b0);
		convert(3'b111, 3'b000, 0, 1'b1);
		rc_run <= 1'b0;
		bus(`ADCS_OFF_RESULT_HIGH, 1'b1, 8'h5A);
		bus(`ADCS_OFF_RESULT_LOW, 1'b1, 8'hC3);
		bus(`ADCS_OFF_TIMING_FORMAT, 1'b1, 8'h01);
		bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b1, 8'h03);
		repeat (40) @(posedge core_clk);
		bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b1, 8'h01);
		expect_reg(`ADCS_OFF_CONTROL_CHANNEL, 8'h01, "run after abort");
		repeat (40) @(posedge core_clk);
		expect_reg(`ADCS_OFF_RESULT_HIGH, 8'h5A, "result high kept");
		expect_reg(`ADCS_OFF_RESULT_LOW, 8'hC3, "result low kept");
		expect_reg(`ADCS_OFF_STATUS, 8'h00, "done after abort");
		bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b1, 8'h03);
		repeat (30) @(posedge core_clk);
		fuse <= 1'b1;
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		expect_reg(`ADCS_OFF_REFERENCE_PINS, 8'h00, "fuse analog reset");
		expect_reg(`ADCS_OFF_CONTROL_CHANNEL, 8'h00, "control after reset");
		check(analog_out.dac_code === 10'h000, "converter idle after reset");
		bus(`ADCS_OFF_CONTROL_CHANNEL, 1'b1, 8'h03);
		expect_reg(`ADCS_OFF_CONTROL_CHANNEL, 8'h01, "run ignored at switch-on");
		report_and_stop();
	end
endmodule
